// >>> fps_regs.vh
// Constants for the flyback protection supervisor: register map,
// field positions, reset values and protection timing.
// Assumes a 100 MHz clock; delays are given in microseconds, blanking and window in nanoseconds.
`ifndef FPS_REGS_VH
`define FPS_REGS_VH

// Register offsets (word index on the plain port)
`define FPS_ADDR_CTRL      4'h0
`define FPS_ADDR_STATUS    4'h1
`define FPS_ADDR_IRQ_STAT  4'h2
`define FPS_ADDR_IRQ_MASK  4'h3
`define FPS_ADDR_ABNORMAL_OVERCURRENT_TRIP_CFG  4'h4
`define FPS_ADDR_ABNORMAL_OVERCURRENT_TRIP_CNT  4'h5

// Control fields
`define FPS_CTRL_EN_BIT       0
`define FPS_CTRL_LINE_DET_BIT 1
`define FPS_CTRL_RESET        2'h0

// Event bits (status, irq status and irq mask share the layout)
`define FPS_EV_OLP   0
`define FPS_EV_OVP   1
`define FPS_EV_ABNORMAL_OVERCURRENT_TRIP  2
`define FPS_EV_BO    3
`define FPS_EV_LINE_OVERVOLTAGE_HALT  4
`define FPS_EV_TSD   5
`define FPS_EV_W     6
`define FPS_EV_NONE  6'h00

// Abnormal overcurrent configuration
`define FPS_TRIG_LSB       0
`define FPS_HALT_LSB       4
`define FPS_TRIG_RESET     4'h2
`define FPS_HALT_RESET     4'h8
`define FPS_EVENT_LIMIT    2'h3

// Protection times in microseconds; blanking and window in nanoseconds
`define FPS_OLP_DELAY_US   55000
`define FPS_OVP_DELAY_US   100
`define FPS_BO_DELAY_US    50000
`define FPS_AR_DELAY_US    1000000
`define FPS_LEB_NS         250
`define FPS_ABNORMAL_OVERCURRENT_TRIP_WIN_NS    150
`define FPS_CLK_MHZ        100
`define FPS_NS_PER_US      1000

`endif

// >>> fps_protection_fsm.v
// Protection supervisor for a peak-current-mode flyback controller.
// Comparator inputs are synchronous to clk; the supply comparators and
// the high-voltage source sit in the analog power stage outside.
`timescale 1ns/1ps
`include "fps_regs.vh"

// Summary of operation
// RQ1: Overload held for overload_delay trips overload and stops switching.
// RQ2: Protection keeps HV source supplying power for auto_restart_delay.
// RQ3: After the delay, let supply fall to stop threshold, clear, restart.
// RQ4: Supply above overvoltage threshold for its delay trips overvoltage.
// RQ5: Overcurrent sampled only in blanking plus window of each cycle.
// RQ6: Trigger-count consecutive overcurrent cycles halt for halt-pulse cycles.
// RQ7: Third overcurrent halt event enters protection mode.
// RQ8: With line detection, withhold start until line reaches brown-in.
// RQ9: Line below brown-out for brown_out_delay in run enters protection.
// RQ10: Line overvoltage halts switching until below recovery threshold.
// RQ11: Soft start on resume after line overvoltage or brown-in.
// RQ12: Over-temperature trips thermal shutdown and enters protection.
// RQ13: No resume while temperature at or above recovery temperature.
// RQ14: Line checks apply only when line detection is enabled.
// RQ15: Inputs are synchronous flags; delays are restartable cycle counters.
module fps_protection_fsm #(
    parameter OLP_CYC  = (`FPS_OLP_DELAY_US * `FPS_CLK_MHZ),
    parameter OVP_CYC  = (`FPS_OVP_DELAY_US * `FPS_CLK_MHZ),
    parameter BO_CYC   = (`FPS_BO_DELAY_US * `FPS_CLK_MHZ),
    parameter AR_CYC   = (`FPS_AR_DELAY_US * `FPS_CLK_MHZ),
    parameter CNT_W    = 27
)(
    // Clock and reset
    input  wire        clk,
    input  wire        srst,
    // Register port
    input  wire [3:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    // Comparator flags from the power stage
    input  wire        comp_above_olp,
    input  wire        vcc_above_ovp,
    input  wire        vcc_below_stop,
    input  wire        drain_over_limit,
    input  wire        cycle_start,
    input  wire        line_above_bi,
    input  wire        line_below_bo,
    input  wire        line_above_ovp,
    input  wire        line_below_ovp_rec,
    input  wire        temp_above_sd,
    input  wire        temp_below_rec,
    // Controls to the power stage and the interrupt
    output reg         switch_en,
    output reg         soft_start,
    output reg         hv_source_en,
    output reg         irq
);
    localparam LEB_CYC = ((`FPS_LEB_NS + `FPS_ABNORMAL_OVERCURRENT_TRIP_WIN_NS) * `FPS_CLK_MHZ)
                         / `FPS_NS_PER_US;

    // One-hot states
    localparam [4:0] S_WAIT = 5'h01;
    localparam [4:0] S_SOFT = 5'h02;
    localparam [4:0] S_RUN  = 5'h04;
    localparam [4:0] S_PROT = 5'h08;
    localparam [4:0] S_DRN  = 5'h10;

    reg [4:0]  state_q;
    reg [1:0]  ctrl_q;
    reg [7:0]  abnormal_overcurrent_trip_cfg_q;
    reg [5:0]  irq_stat_q;
    reg [5:0]  irq_mask_q;
    reg [5:0]  cause_q;
    reg [CNT_W-1:0] olp_cnt_q;
    reg [CNT_W-1:0] ovp_cnt_q;
    reg [CNT_W-1:0] bo_cnt_q;
    reg [CNT_W-1:0] ar_cnt_q;
    reg [7:0]  leb_cnt_q;
    reg [3:0]  trig_cnt_q;
    reg [3:0]  halt_cnt_q;
    reg [1:0]  abnormal_overcurrent_trip_ev_q;
    reg        cyc_hit_q;
    reg        line_overvoltage_halt_q;
    reg        tsd_q;

    wire line_det = ctrl_q[`FPS_CTRL_LINE_DET_BIT];
    wire enabled  = ctrl_q[`FPS_CTRL_EN_BIT];
    wire [3:0] trig_n = abnormal_overcurrent_trip_cfg_q[`FPS_TRIG_LSB +: 4];
    wire [3:0] halt_n = abnormal_overcurrent_trip_cfg_q[`FPS_HALT_LSB +: 4];
    wire in_window = (leb_cnt_q != 8'h00); // [RQ5]
    wire olp_trip = (olp_cnt_q == OLP_CYC[CNT_W-1:0]);
    wire ovp_trip = (ovp_cnt_q == OVP_CYC[CNT_W-1:0]);
    wire bo_trip  = (bo_cnt_q == BO_CYC[CNT_W-1:0]) && line_det;
    wire line_overvoltage_halt_now = line_det && line_above_ovp;             // [RQ10] [RQ14]
    wire abnormal_overcurrent_trip_halt_done;
    wire abnormal_overcurrent_trip_evt;
    wire abnormal_overcurrent_trip_prot;
    wire [5:0] ev_d;

    // Leading-edge window timer and consecutive overcurrent count
    assign abnormal_overcurrent_trip_evt  = cycle_start && cyc_hit_q && (halt_cnt_q == 4'h0)
                       && (trig_cnt_q + 4'h1 >= trig_n);    // [RQ6]
    assign abnormal_overcurrent_trip_prot = abnormal_overcurrent_trip_evt && (abnormal_overcurrent_trip_ev_q == `FPS_EVENT_LIMIT - 2'h1);
    assign abnormal_overcurrent_trip_halt_done = (halt_cnt_q == 4'h0);

    always @(posedge clk)
    begin
        if (srst || state_q != S_RUN)
        begin
            leb_cnt_q  <= 8'h00;
            cyc_hit_q  <= 1'b0;
            trig_cnt_q <= 4'h0;
            halt_cnt_q <= 4'h0;
        end
        else if (cycle_start)
        begin
            leb_cnt_q <= LEB_CYC[7:0];
            cyc_hit_q <= 1'b0;
            if (halt_cnt_q != 4'h0)
                halt_cnt_q <= halt_cnt_q - 4'h1;            // [RQ6]
            else if (abnormal_overcurrent_trip_evt)
            begin
                halt_cnt_q <= halt_n;                       // [RQ6]
                trig_cnt_q <= 4'h0;
            end
            else if (cyc_hit_q)
                trig_cnt_q <= trig_cnt_q + 4'h1;
            else
                trig_cnt_q <= 4'h0;                         // [RQ6]
        end
        else
        begin
            if (in_window)
                leb_cnt_q <= leb_cnt_q - 8'h01;
            if (in_window && drain_over_limit)
                cyc_hit_q <= 1'b1;                          // [RQ5]
        end
    end

    // Halt-event counter survives until the protection state clears
    always @(posedge clk)
    begin
        if (srst || state_q == S_DRN)
            abnormal_overcurrent_trip_ev_q <= 2'h0;
        else if (abnormal_overcurrent_trip_evt && abnormal_overcurrent_trip_ev_q != `FPS_EVENT_LIMIT)
            abnormal_overcurrent_trip_ev_q <= abnormal_overcurrent_trip_ev_q + 2'h1;                  // [RQ7]
    end

    // Restartable delay counters; they saturate at their trip count
    always @(posedge clk)
    begin
        if (srst || state_q != S_RUN || !comp_above_olp)
            olp_cnt_q <= {CNT_W{1'b0}};                     // [RQ15]
        else if (!olp_trip)
            olp_cnt_q <= olp_cnt_q + 1'b1;                  // [RQ1]
        if (srst || state_q != S_RUN || !vcc_above_ovp)
            ovp_cnt_q <= {CNT_W{1'b0}};                     // [RQ15]
        else if (!ovp_trip)
            ovp_cnt_q <= ovp_cnt_q + 1'b1;                  // [RQ4]
        if (srst || state_q != S_RUN || !line_below_bo || !line_det)
            bo_cnt_q <= {CNT_W{1'b0}};                      // [RQ15]
        else if (!bo_trip)
            bo_cnt_q <= bo_cnt_q + 1'b1;                    // [RQ9]
    end

    // Line overvoltage hysteresis and thermal latch
    always @(posedge clk)
    begin
        if (srst || !line_det)
            line_overvoltage_halt_q <= 1'b0;                                 // [RQ14]
        else if (line_overvoltage_halt_now)
            line_overvoltage_halt_q <= 1'b1;                                 // [RQ10]
        else if (line_below_ovp_rec)
            line_overvoltage_halt_q <= 1'b0;                                 // [RQ10]
        if (srst)
            tsd_q <= 1'b0;
        else if (temp_above_sd)
            tsd_q <= 1'b1;                                  // [RQ12]
        else if (temp_below_rec)
            tsd_q <= 1'b0;                                  // [RQ13]
    end

    assign ev_d[`FPS_EV_OLP]  = olp_trip;
    assign ev_d[`FPS_EV_OVP]  = ovp_trip;
    assign ev_d[`FPS_EV_ABNORMAL_OVERCURRENT_TRIP] = abnormal_overcurrent_trip_prot;
    assign ev_d[`FPS_EV_BO]   = bo_trip;
    assign ev_d[`FPS_EV_LINE_OVERVOLTAGE_HALT] = line_overvoltage_halt_now && !line_overvoltage_halt_q;
    assign ev_d[`FPS_EV_TSD]  = temp_above_sd && !tsd_q;

    // Main sequencer
    always @(posedge clk)
    begin
        if (srst)
        begin
            state_q  <= S_WAIT;
            ar_cnt_q <= {CNT_W{1'b0}};
            cause_q  <= `FPS_EV_NONE;
        end
        else
        begin
            case (state_q)
            S_WAIT:
                // Line gate is bypassed when detection is off
                if (enabled && !tsd_q && !line_overvoltage_halt_q
                    && (!line_det || line_above_bi))        // [RQ8] [RQ13]
                    state_q <= S_SOFT;                      // [RQ11]
            S_SOFT:
                state_q <= S_RUN;
            S_RUN:
                if (olp_trip || ovp_trip || abnormal_overcurrent_trip_prot || bo_trip
                    || temp_above_sd)                       // [RQ1] [RQ4]
                begin
                    state_q  <= S_PROT;                     // [RQ7] [RQ9]
                    ar_cnt_q <= {CNT_W{1'b0}};              // [RQ12]
                    cause_q  <= ev_d;
                end
                else if (line_overvoltage_halt_now || !enabled)
                    state_q <= S_WAIT;                      // [RQ10]
            S_PROT:
                if (ar_cnt_q == AR_CYC[CNT_W-1:0])
                    state_q <= S_DRN;                       // [RQ2]
                else
                    ar_cnt_q <= ar_cnt_q + 1'b1;            // [RQ2]
            S_DRN:
                // Supply must decay to the stop level before restart
                if (vcc_below_stop)
                begin
                    state_q <= S_WAIT;                      // [RQ3]
                    cause_q <= `FPS_EV_NONE;                // [RQ3]
                end
            default:
                state_q <= S_WAIT;
            endcase
        end
    end

    // Registered outputs to the power stage
    always @(posedge clk)
    begin
        if (srst)
        begin
            switch_en    <= 1'b0;
            soft_start   <= 1'b0;
            hv_source_en <= 1'b0;
        end
        else
        begin
            switch_en    <= (state_q == S_RUN) && abnormal_overcurrent_trip_halt_done
                            && !line_overvoltage_halt_now && !olp_trip && !ovp_trip
                            && !temp_above_sd && !abnormal_overcurrent_trip_evt; // [RQ1] [RQ6]
            soft_start   <= (state_q == S_SOFT);            // [RQ11]
            hv_source_en <= (state_q == S_PROT);            // [RQ2]
        end
    end

    // Register file and interrupt status; a set beats a read-clear
    always @(posedge clk)
    begin
        if (srst)
        begin
            ctrl_q     <= `FPS_CTRL_RESET;
            abnormal_overcurrent_trip_cfg_q <= {`FPS_HALT_RESET, `FPS_TRIG_RESET};
            irq_mask_q <= `FPS_EV_NONE;
            irq_stat_q <= `FPS_EV_NONE;
            reg_rdata  <= 32'h0000_0000;
            irq        <= 1'b0;
        end
        else
        begin
            if (reg_wr && reg_addr == `FPS_ADDR_CTRL)
                ctrl_q <= reg_wdata[1:0];
            if (reg_wr && reg_addr == `FPS_ADDR_IRQ_MASK)
                irq_mask_q <= reg_wdata[5:0];
            if (reg_wr && reg_addr == `FPS_ADDR_ABNORMAL_OVERCURRENT_TRIP_CFG)
                abnormal_overcurrent_trip_cfg_q <= reg_wdata[7:0];
            if (reg_rd && reg_addr == `FPS_ADDR_IRQ_STAT)
                irq_stat_q <= ev_d;
            else
                irq_stat_q <= irq_stat_q | ev_d;
            irq <= |(irq_stat_q & irq_mask_q);
            reg_rdata <= 32'h0000_0000;
            if (reg_rd)
            begin
                case (reg_addr)
                `FPS_ADDR_CTRL:     reg_rdata <= {30'h0, ctrl_q};
                `FPS_ADDR_STATUS:   reg_rdata <= {21'h0, state_q,
                                                  cause_q};
                `FPS_ADDR_IRQ_STAT: reg_rdata <= {26'h0, irq_stat_q};
                `FPS_ADDR_IRQ_MASK: reg_rdata <= {26'h0, irq_mask_q};
                `FPS_ADDR_ABNORMAL_OVERCURRENT_TRIP_CFG: reg_rdata <= {24'h0, abnormal_overcurrent_trip_cfg_q};
                `FPS_ADDR_ABNORMAL_OVERCURRENT_TRIP_CNT: reg_rdata <= {26'h0, line_overvoltage_halt_q, tsd_q,
                                                  abnormal_overcurrent_trip_ev_q, 2'h0};
                default:            reg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

// >>> fps_asserts.sv
// Port checker for the protection supervisor.
// Assumes a bind onto fps_protection_fsm with its delay parameters.
`timescale 1ns/1ps
module fps_chk #(
    parameter OLP_CYC = 20,
    parameter OVP_CYC = 10,
    parameter AR_CYC  = 50
)(
    // Clock and reset
    input logic        clk,
    input logic        srst,
    // Register port
    input logic        reg_rd,
    input logic [31:0] reg_rdata,
    // Fault flags
    input logic        comp_above_olp,
    input logic        vcc_above_ovp,
    input logic        temp_above_sd,
    input logic        temp_below_rec,
    // Stage controls
    input logic        switch_en,
    input logic        soft_start,
    input logic        hv_source_en
);
    int   olp_q;
    int   ovp_q;
    int   hv_q;
    logic hot_q;
    default clocking dcb @(posedge clk); endclocking
    default disable iff (srst);
    // Counts restart as soon as their condition drops
    always @(posedge clk)
    begin
        olp_q <= (srst || !(comp_above_olp && switch_en)) ? 0 : olp_q + 1;
        ovp_q <= (srst || !(vcc_above_ovp && switch_en)) ? 0 : ovp_q + 1;
        hv_q  <= (srst || !hv_source_en) ? 0 : hv_q + 1;
        hot_q <= srst ? 1'b0 : (temp_above_sd | (hot_q & ~temp_below_rec));
    end
    a_olp_stop: assert property (olp_q == OLP_CYC |-> ##[0:3] !switch_en)
        else $error("overload did not stop switching");
    a_ovp_stop: assert property (ovp_q == OVP_CYC |-> ##[0:3] !switch_en)
        else $error("supply overvoltage did not stop switching");
    a_hv_hold: assert property ($rose(hv_source_en) |-> hv_source_en[*8])
        else $error("high-voltage source dropped early");
    a_hv_excl: assert property (hv_source_en |-> !switch_en)
        else $error("switching while in protection");
    a_ar_len: assert property ($fell(hv_source_en) |->
        hv_q >= AR_CYC - 2 && hv_q <= AR_CYC + 2)
        else $error("auto-restart delay length wrong");
    a_soft_run: assert property (soft_start |=> switch_en)
        else $error("soft start not followed by switching");
    a_tsd_stop: assert property (temp_above_sd && switch_en
        |-> ##[1:3] !switch_en)
        else $error("over-temperature did not stop switching");
    a_hot_hold: assert property (hot_q && !switch_en |=> !switch_en)
        else $error("switching resumed while still hot");
    a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside the read slot");
endmodule

// >>> fps_stage_model.sv
// Power stage model: switching cycle pulses and supply collapse.
// Assumes supply drops to the stop level once the HV source is off.
`timescale 1ns/1ps
module fps_stage_model (
    // Clock and reset
    input  logic clk,
    input  logic srst,
    // Controls from the supervisor
    input  logic switch_en,
    input  logic hv_source_en,
    // Sensing back to the supervisor
    output logic cycle_start,
    output logic vcc_below_stop
);
    logic [2:0] ph_q;
    logic [3:0] dly_q;
    logic       hv_q;
    // Oscillator pulse every eight clocks; it keeps running while
    // switching is halted, so halt pulses can still be counted
    always @(posedge clk)
    begin
        ph_q        <= srst ? 3'h0 : ph_q + 3'h1;
        cycle_start <= !srst && ph_q == 3'h7;
        hv_q        <= !srst && hv_source_en;
        // Supply sags for a while after the source turns off
        if (srst)
            dly_q <= 4'h0;
        else if (hv_q && !hv_source_en)
            dly_q <= 4'h6;
        else if (dly_q != 4'h0)
            dly_q <= dly_q - 4'h1;
        vcc_below_stop <= dly_q == 4'h2 || dly_q == 4'h1;
    end
endmodule

// >>> flyback_protection_fsm_tb.sv
// Self-checking bench for the protection supervisor.
// Assumes short delay parameters so every trip runs in a few cycles.
`timescale 1ns/1ps
module flyback_protection_fsm_tb;
    logic        clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, rd_q = 0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, r;
    logic [4:0]  flt = 5'h00;
    logic        bi = 0, lov = 0, lrec = 1, trec = 1;
    logic        cyc, vstop, sw, ss, hv, irq;
    logic [31:0] q[$];
    int          n_errors = 0, n_compared = 0, k;
    int          cb[5] = '{0, 1, 2, 3, 5};
    always #5 clk = ~clk;
    fps_protection_fsm #(.OLP_CYC(20), .OVP_CYC(10), .BO_CYC(20),
        .AR_CYC(50)) u_dut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .comp_above_olp(flt[0]),
        .vcc_above_ovp(flt[1]), .vcc_below_stop(vstop),
        .drain_over_limit(flt[2]), .cycle_start(cyc),
        .line_above_bi(bi), .line_below_bo(flt[3]),
        .line_above_ovp(lov), .line_below_ovp_rec(lrec),
        .temp_above_sd(flt[4]), .temp_below_rec(trec), .switch_en(sw),
        .soft_start(ss), .hv_source_en(hv), .irq(irq));
    fps_stage_model u_stage (.clk(clk), .srst(srst), .switch_en(sw),
        .hv_source_en(hv), .cycle_start(cyc), .vcc_below_stop(vstop));
    function logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input string nm, input logic [31:0] got, input logic [31:0] ex);
        n_compared++;
        if (got !== ex)
        begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, ex, got);
        end
    endtask
    task close_out;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Expected read data is queued; the monitor below pairs it up
    task rd(input logic [3:0] a, input logic [31:0] ex);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        q.push_back(ex);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    always @(posedge clk)
    begin
        if (rd_q)
            chk("rdata", reg_rdata, q.pop_front());
        rd_q <= reg_rd;
    end
    function logic hit(input int w);
        case (w)
            0: return hv;
            1: return !hv;
            2: return sw;
            3: return ss;
            default: return !sw;
        endcase
    endfunction
    // Bounded wait, sampled mid-cycle so edge updates have landed
    task wt(input int w, input int lim);
        int i;
        i = 0;
        do
        begin
            @(negedge clk);
            i++;
        end
        while (!hit(w) && i < lim);
        chk("wait", hit(w), 1'b1);
        @(posedge clk);
    endtask
    initial
    begin
        #200000;
        n_errors++;
        close_out;
    end
    initial
    begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        rd(4'h0, 32'h0);
        rd(4'h3, 32'h0);
        rd(4'h4, 32'h82);
        rd(4'hf, 32'h0);
        rd(4'h1, 32'h40);
        r = lfsr(32'h5364);
        wr(4'h3, r);
        rd(4'h3, r & 32'h3f);
        wr(4'hf, r);
        rd(4'h0, 32'h0);
        wr(4'h0, 32'h3);
        repeat (20) @(posedge clk);
        @(negedge clk);
        chk("switch_en", sw, 1'b0);
        rd(4'h1, 32'h40);
        bi <= 1'b1;
        wt(3, 20);
        wt(2, 20);
        rd(4'h1, 32'h100);
        // Each fault in turn, the first one with its interrupt masked
        for (k = 0; k < 5; k++)
        begin
            wr(4'h3, k ? 32'h3f : 32'h0);
            flt[k] <= 1'b1;
            trec <= k != 4;
            wt(0, 400);
            flt[k] <= 1'b0;
            rd(4'h1, 32'h200 | (32'h1 << cb[k]));
            @(negedge clk);
            chk("irq", irq, k != 0);
            rd(4'h2, 32'h1 << cb[k]);
            wt(1, 100);
            if (k == 4)
            begin
                repeat (60) @(negedge clk);
                chk("switch_en", sw, 1'b0);
                @(posedge clk);
                trec <= 1'b1;
            end
            wt(2, 100);
            chk("irq", irq, 1'b0);
        end
        lov <= 1'b1;
        lrec <= 1'b0;
        wt(4, 10);
        lov <= 1'b0;
        repeat (10) @(negedge clk);
        chk("switch_en", sw, 1'b0);
        rd(4'h2, 32'h10);
        lrec <= 1'b1;
        wt(3, 20);
        wt(2, 20);
        wr(4'h0, 32'h1);
        flt[3] <= 1'b1;
        repeat (40) @(negedge clk);
        chk("switch_en", sw, 1'b1);
        @(posedge clk);
        flt[3] <= 1'b0;
        repeat (4) @(posedge clk);
        close_out;
    end
endmodule
bind fps_protection_fsm fps_chk #(.OLP_CYC(OLP_CYC), .OVP_CYC(OVP_CYC),
    .AR_CYC(AR_CYC)) u_chk (.clk(clk), .srst(srst), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .comp_above_olp(comp_above_olp),
    .vcc_above_ovp(vcc_above_ovp), .temp_above_sd(temp_above_sd),
    .temp_below_rec(temp_below_rec), .switch_en(switch_en),
    .soft_start(soft_start), .hv_source_en(hv_source_en));
